// ===== dv/disc_model.sv
// Disc side model: spindle oscillator pulses and frame sync level.
`timescale 1ns/1ns
`default_nettype none
module disc_model #(
    parameter int HALF = 2
) (
    input  wire logic aclk,
    input  wire logic spin_on,
    input  wire logic sync_on,
    output var  logic osc_out,
    output var  logic sync_out
);
    int cnt;
    // Toggles every HALF cycles while spinning; rests low when stopped.
    always_ff @(posedge aclk) begin
        cnt <= (!spin_on || cnt == HALF - 1) ? 0 : cnt + 1;
        osc_out <= spin_on && (cnt == HALF - 1 ? !osc_out : osc_out);
    end
    // Frame sync good as the disc presents it.
    assign sync_out = sync_on;
endmodule
`default_nettype wire

// ===== dv/spindle_pll_checker_asserts.sv
// Port-level assertions for the spindle and PLL mode controller.
`timescale 1ns/1ns
`default_nettype none
module spindle_pll_checker
    import spindle_pll_pkg::*;
#(
    parameter int LOCK_SAMPLE_CNT = 20
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       frame_sync_good,
    input wire logic [1:0] spindle_drive_out,
    input wire logic       serial_readout_pin,
    input wire logic       vco_clock_sixteen,
    input wire logic       phase_compare_out,
    input wire logic       sample_clock_from_disc
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    int hi_run;
    int lo_run;
    // Counts how long frame sync has held its present level.
    always_ff @(posedge aclk) begin
        hi_run <= (!aresetn || !frame_sync_good) ? 0 : hi_run + 1;
        lo_run <= (!aresetn || frame_sync_good) ? 0 : lo_run + 1;
    end
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    lock_rise_a: assert property ($rose(serial_readout_pin) |-> hi_run >= 7 * LOCK_SAMPLE_CNT)
        else $error("lock set before eight high samples");
    lock_fall_a: assert property ($fell(serial_readout_pin) |-> lo_run >= 7 * LOCK_SAMPLE_CNT)
        else $error("lock cleared before eight low samples");
    cav_vco_excl_a: assert property (sample_clock_from_disc |-> !vco_clock_sixteen)
        else $error("angular and oscillator modes together");
    cav_clvw_excl_a: assert property (sample_clock_from_disc |-> !phase_compare_out)
        else $error("angular and wide linear modes together");
    vco_drive_off_a: assert property (vco_clock_sixteen |-> spindle_drive_out == DRIVE_OFF)
        else $error("spindle driven in oscillator mode");
endmodule
bind spindle_pll_mode_control spindle_pll_checker #(
    .LOCK_SAMPLE_CNT(LOCK_SAMPLE_CNT)
) u_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .frame_sync_good(frame_sync_good), .spindle_drive_out(spindle_drive_out),
    .serial_readout_pin(serial_readout_pin), .vco_clock_sixteen(vco_clock_sixteen),
    .phase_compare_out(phase_compare_out), .sample_clock_from_disc(sample_clock_from_disc)
);
`default_nettype wire

// ===== dv/tb_top.sv
// Self-checking testbench for the spindle and PLL mode controller.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import spindle_pll_pkg::*;
    logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0;
    logic        arvalid = '0, rready = '0, pwm = '0, spin = '0, son = '0;
    logic [7:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_v;
    logic        awready, wready, bvalid, arready, rvalid, fsg, osc, lock, vco16, pco, scd;
    logic [1:0]  bresp, rresp, drive, rd_r;
    int          num_errors = 0, num_checks = 0;
    logic [7:0]  tc [10] = '{8'h42, 8'h42, 8'h52, 8'h01, 8'h11, 8'h01, 8'h00, 8'h46, 8'h46, 8'h4A};
    logic [7:0]  tp [10] = '{8'hE1, 8'hFE, 8'hFE, 8'hFE, 8'hFE, 8'hE1, 8'hFE, 8'hFE, 8'hE1, 8'hFE};
    logic [3:0]  te [10] = '{4'h2, 4'h4, 4'h0, 4'h4, 4'h0, 4'h3, 4'h4, 4'hA, 4'h4, 4'h2};
    // Clock at 125 MHz.
    always #4 aclk = ~aclk;
    spindle_pll_mode_control #(.LOCK_SAMPLE_CNT(20)) DUT (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_sync_good(fsg), .external_pwm_in(pwm), .external_osc_clock_in(osc),
        .spindle_drive_out(drive), .serial_readout_pin(lock), .vco_clock_sixteen(vco16),
        .phase_compare_out(pco), .sample_clock_from_disc(scd));
    disc_model u_disc (.aclk(aclk), .spin_on(spin), .sync_on(son), .osc_out(osc), .sync_out(fsg));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic give_up();
        num_errors++;
        $display("MISMATCH wait expected done seen timeout");
        stop_test();
    endtask
    // Bus write: address and data offered together, each released when taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        rd_r = bresp;
        if (n >= 50) give_up();
    endtask
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        {rd_v, rd_r} = {rdata, rresp};
        if (n >= 50) give_up();
    endtask
    task automatic wait_lock(input logic v);
        int n = 0;
        while (lock !== v && n < 400) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 400) give_up();
    endtask
    task automatic t_reset();
        rd(CTRL_OFS);
        chk("ctrl_rst", rd_v, CTRL_RST);
        rd(PRESET_OFS);
        chk("preset_rst", rd_v[7:0], PRESET_RST);
        rd(8'h1C);
        chk("bad_rd", {rd_v[29:0], rd_r}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 32'h0000_0001);
        chk("bad_wr", rd_r, RESP_SLVERR);
        wr(STATUS_OFS, 32'hFFFF_FFFF);
        rd(STATUS_OFS);
        chk("ro_status", {rd_r, rd_v[3:2]}, {RESP_OKAY, 2'h0});
        $display("test reset done");
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            wr(CTRL_OFS, 32'h0000_0400 | m | (m == 2 ? 32'h0000_0040 : 32'h0));
            rd(CTRL_OFS);
            chk("pitch", rd_v[10], m != 0);
            rd(STATUS_OFS);
            chk("mode", rd_v[3:2], m);
            chk("rot_loop", rd_v[9], m == 1);
            chk("disc_clk", scd, m == 2);
            rd(CAPTURE_OFS);
            chk("capture", rd_v, m == 0 ? CAPTURE_NARROW : CAPTURE_WIDE);
        end
        wr(CTRL_OFS, 32'h0000_0040);
        rd(CAPTURE_OFS);
        chk("cap_floff", rd_v, CAPTURE_FLOFF);
        rd(STATUS_OFS);
        chk("stages", rd_v[9:4], 6'h0F);
        $display("test modes done");
    endtask
    task automatic t_vco();
        int n = 0;
        wr(PRESET_OFS, 32'h0000_00F0);
        for (int s = 0; s < 2; s++) begin
            wr(CTRL_OFS, 32'h0000_0303 | (s << SPEED_BIT));
            rd(VCO_OFS);
            chk("vco_word", rd_v, 32'h0000_0030);
            rd(OSC1_OFS);
            chk("osc1", rd_v, s ? 32'h0000_0093 : 32'h0000_0062);
        end
        while (vco16 !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 2000) give_up();
        chk("vco_drive", drive, DRIVE_OFF);
        $display("test vco done");
    endtask
    task automatic t_drive();
        spin <= 1'b1;
        repeat (300) @(posedge aclk);
        rd(VELOCITY_OFS);
        chk("velocity", rd_v >= 7 && rd_v <= 9, 1'b1);
        for (int i = 0; i < 10; i++) begin
            pwm <= te[i][3];
            wr(PRESET_OFS, {24'h0, tp[i]});
            wr(CTRL_OFS, {24'h0, tc[i]});
            repeat (4) @(posedge aclk);
            chk("drive", drive, te[i][2:1]);
            chk("phase_out", pco, te[i][0]);
        end
        $display("test drive done");
    endtask
    task automatic t_lock();
        wr(CTRL_OFS, 32'h0000_004A);
        son <= 1'b1;
        repeat (100) @(posedge aclk);
        chk("lock_early", lock, 1'b0);
        wait_lock(1'b1);
        rd(STATUS_OFS);
        chk("lock_reg", rd_v[0], 1'b1);
        wr(CTRL_OFS, 32'h0000_0001);
        son <= 1'b0;
        repeat (100) @(posedge aclk);
        chk("lock_hold", lock, 1'b1);
        wait_lock(1'b0);
        wr(CTRL_OFS, 32'h0000_0042);
        rd(STATUS_OFS);
        chk("back_cav", rd_v[3:0], 4'h8);
        $display("test lock done");
    endtask
    // Main sequence: reset for ten cycles, then each scenario in turn.
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset();
        t_modes();
        t_vco();
        t_drive();
        t_lock();
        stop_test();
    end
endmodule
`default_nettype wire

// ===== src/spindle_pll_mode_control.sv
// Spindle and clock-recovery PLL mode controller with an AXI4-Lite register slave.
//
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - Narrow linear mode captures within 150 kHz.
// - Variable pitch is forced off while narrow linear mode is selected.
// - Auto lock flag is driven on the serial readout pin.
// - Low power in wide linear mode drops deceleration pulses.
// - Angular mode drives the spindle toward the 8-bit velocity preset.
// - External PWM angular mode: input high kicks, input low brakes.
// - Crystal over 128 gates a count of half-rate oscillator pulses, 10 bits.
// - Measurement target equals 256 minus the velocity preset.
// - Angular mode takes the system sample clock from the disc oscillator.
// - Oscillator control frequency is range times 256 minus preset.
// - First oscillator is that frequency times 49/24, or 49/16 with speed select.
// - Three PLL stages: wide-band reference, high-rate clock, digital recovery.
// - Narrow mode runs phase and frequency loops; loop off narrows to 50 kHz.
// - Wide linear mode adds a rotation-following digital PLL.
// - Auto lock samples frame sync at 460 Hz, eight equal samples change it.
module spindle_pll_mode_control #(
    parameter int LOCK_SAMPLE_CNT = spindle_pll_pkg::LOCK_SAMPLE_CYCLES
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        frame_sync_good,
    input  wire logic        external_pwm_in,
    input  wire logic        external_osc_clock_in,
    output var  logic [1:0]  spindle_drive_out,
    output var  logic        serial_readout_pin,
    output var  logic        vco_clock_sixteen,
    output var  logic        phase_compare_out,
    output var  logic        sample_clock_from_disc
);
    import spindle_pll_pkg::*;

    // Merges a write word into a register under the byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [7:0]  preset_ff, nxt_preset;
    logic        aw_held_ff, nxt_aw_held;
    logic        w_held_ff, nxt_w_held;
    logic [7:0]  awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0]  wstrb_ff, nxt_wstrb;
    logic        awready_ff, nxt_awready;
    logic        wready_ff, nxt_wready;
    logic        bvalid_ff, nxt_bvalid;
    logic [1:0]  bresp_ff, nxt_bresp;
    logic        arready_ff, nxt_arready;
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;
    logic [2:0]  fs_sync_ff, pwm_sync_ff, osc_sync_ff;
    logic [2:0]  nxt_fs_sync, nxt_pwm_sync, nxt_osc_sync;
    logic [REF_DIV_BITS-1:0] ref_cnt_ff, nxt_ref_cnt;
    logic        half_ff, nxt_half;
    logic [9:0]  meas_cnt_ff, nxt_meas_cnt;
    logic [9:0]  velocity_ff, nxt_velocity;
    logic [31:0] sample_cnt_ff, nxt_sample_cnt;
    logic [3:0]  hi_run_ff, nxt_hi_run, lo_run_ff, nxt_lo_run;
    logic        lock_ff, nxt_lock;
    logic [1:0]  drive_ff, nxt_drive;
    logic        readout_ff, nxt_readout;
    logic [15:0] nco_ff, nxt_nco;
    logic        phase_ff, nxt_phase;
    logic        disc_clk_ff, nxt_disc_clk;

    spin_mode_t  mode;
    logic [8:0]  target;
    logic [9:0]  v16_word;
    logic [15:0] osc1_word;
    logic [7:0]  capture_khz;
    logic [5:0]  stage_bits;
    logic        pitch_active;
    logic        wr_go;
    logic [1:0]  servo_cmd;

    // Decoded control fields; the mode field holds exactly one mode at a time.
    always_comb begin
        mode         = spin_mode_t'(ctrl_ff[MODE_LSB +: 2]);
        target       = PRESET_BASE - {1'b0, preset_ff};
        servo_cmd    = (velocity_ff < {1'b0, target}) ? DRIVE_ACCEL :
                       (velocity_ff > {1'b0, target}) ? DRIVE_DECEL : DRIVE_OFF;
        v16_word     = {8'h00, ctrl_ff[RANGE_LSB +: 2]} * {1'b0, target};
        osc1_word    = ({6'h00, v16_word} * {10'h000, OSC1_MUL})
                       / (ctrl_ff[SPEED_BIT] ? {11'h000, OSC1_DIV_HI}
                                             : {11'h000, OSC1_DIV_LO});
        pitch_active = ctrl_ff[PITCH_BIT] && (mode != MODE_CLV_N);
        // Capture range of the clock recovery loop for the active mode.
        if (mode == MODE_CLV_N) begin
            capture_khz = ctrl_ff[FLOFF_BIT] ? CAPTURE_FLOFF : CAPTURE_NARROW;
        end else begin
            capture_khz = CAPTURE_WIDE;
        end
        // Stages from bit 0: reference, high-rate, digital, phase, frequency, rotation.
        stage_bits   = {(mode == MODE_CLV_W), !ctrl_ff[FLOFF_BIT],
                        4'hF};
    end

    // Write channel: address and data are taken in either order, then answered.
    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held  = w_held_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff;
        nxt_bresp   = bresp_ff;
        nxt_ctrl    = ctrl_ff;
        nxt_preset  = preset_ff;
        wr_go       = aw_held_ff && w_held_ff && !bvalid_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (wr_go) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = RESP_OKAY;
            case (awaddr_ff)
                CTRL_OFS:   nxt_ctrl = merge(ctrl_ff, wdata_ff, wstrb_ff);
                PRESET_OFS: begin
                    if (wstrb_ff[0]) begin
                        nxt_preset = wdata_ff[7:0];
                    end
                end
                STATUS_OFS, VELOCITY_OFS, VCO_OFS, OSC1_OFS, CAPTURE_OFS: nxt_bresp = RESP_OKAY;
                default:    nxt_bresp = RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready  = !nxt_w_held && !nxt_bvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            ctrl_ff    <= CTRL_RST;
            preset_ff  <= PRESET_RST;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            ctrl_ff    <= nxt_ctrl;
            preset_ff  <= nxt_preset;
        end
    end

    // Read channel: one read at a time, data registered one cycle after the address.
    always_comb begin
        nxt_rvalid  = rvalid_ff;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (s_axi_arvalid && arready_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = RESP_OKAY;
            case (s_axi_araddr)
                CTRL_OFS:     nxt_rdata = {21'h0, pitch_active, ctrl_ff[9:0]};
                PRESET_OFS:   nxt_rdata = {24'h0, preset_ff};
                STATUS_OFS:   nxt_rdata = {22'h0, stage_bits, mode, fs_sync_ff[2], lock_ff};
                VELOCITY_OFS: nxt_rdata = {22'h0, velocity_ff};
                VCO_OFS:      nxt_rdata = {22'h0, v16_word};
                OSC1_OFS:     nxt_rdata = {16'h0, osc1_word};
                CAPTURE_OFS:  nxt_rdata = {24'h0, capture_khz};
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= RESP_OKAY;
            arready_ff <= 1'b0;
        end else begin
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
            arready_ff <= nxt_arready;
        end
    end

    // Pin synchronisers; stage 0 feeds only stage 1, stage 2 takes the value of stage 1.
    always_comb begin
        nxt_fs_sync  = {fs_sync_ff[1], fs_sync_ff[0], frame_sync_good};
        nxt_pwm_sync = {pwm_sync_ff[1], pwm_sync_ff[0], external_pwm_in};
        nxt_osc_sync = {osc_sync_ff[1], osc_sync_ff[0], external_osc_clock_in};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_sync_ff  <= 3'h0;
            pwm_sync_ff <= 3'h0;
            osc_sync_ff <= 3'h0;
        end else begin
            fs_sync_ff  <= nxt_fs_sync;
            pwm_sync_ff <= nxt_pwm_sync;
            osc_sync_ff <= nxt_osc_sync;
        end
    end

    // Velocity measurement: count every second rising oscillator edge while the reference is low.
    always_comb begin
        nxt_ref_cnt  = ref_cnt_ff + 1'b1;
        nxt_half     = half_ff;
        nxt_meas_cnt = meas_cnt_ff;
        nxt_velocity = velocity_ff;
        if (!ref_cnt_ff[REF_DIV_BITS-1] && osc_sync_ff[1] && !osc_sync_ff[2]) begin
            nxt_half = !half_ff;
            if (half_ff && meas_cnt_ff != MEAS_MAX) begin
                nxt_meas_cnt = meas_cnt_ff + 1'b1;
            end
        end
        if (ref_cnt_ff == {REF_DIV_BITS{1'b1}}) begin
            nxt_velocity = meas_cnt_ff;
            nxt_meas_cnt = 10'h000;
            nxt_half     = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ref_cnt_ff  <= '0;
            half_ff     <= 1'b0;
            meas_cnt_ff <= 10'h000;
            velocity_ff <= 10'h000;
        end else begin
            ref_cnt_ff  <= nxt_ref_cnt;
            half_ff     <= nxt_half;
            meas_cnt_ff <= nxt_meas_cnt;
            velocity_ff <= nxt_velocity;
        end
    end

    // Auto lock: frame sync sampled at 460 Hz, eight equal samples in a row change the flag.
    always_comb begin
        nxt_sample_cnt = sample_cnt_ff + 32'h0000_0001;
        nxt_hi_run     = hi_run_ff;
        nxt_lo_run     = lo_run_ff;
        nxt_lock       = lock_ff;
        if (sample_cnt_ff >= 32'(LOCK_SAMPLE_CNT - 1)) begin
            nxt_sample_cnt = 32'h0000_0000;
            if (fs_sync_ff[2]) begin
                nxt_lo_run = 4'h0;
                nxt_hi_run = (hi_run_ff == LOCK_RUN) ? LOCK_RUN : hi_run_ff + 1'b1;
                if (hi_run_ff == LOCK_RUN - 1'b1) begin
                    nxt_lock = 1'b1;
                end
            end else begin
                nxt_hi_run = 4'h0;
                nxt_lo_run = (lo_run_ff == LOCK_RUN) ? LOCK_RUN : lo_run_ff + 1'b1;
                if (lo_run_ff == LOCK_RUN - 1'b1) begin
                    nxt_lock = 1'b0;
                end
            end
        end
        nxt_readout = lock_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_cnt_ff <= 32'h0000_0000;
            hi_run_ff     <= 4'h0;
            lo_run_ff     <= 4'h0;
            lock_ff       <= 1'b0;
            readout_ff    <= 1'b0;
        end else begin
            sample_cnt_ff <= nxt_sample_cnt;
            hi_run_ff     <= nxt_hi_run;
            lo_run_ff     <= nxt_lo_run;
            lock_ff       <= nxt_lock;
            readout_ff    <= nxt_readout;
        end
    end

    // Spindle drive, oscillator control output and clock source selection.
    always_comb begin
        case (mode)
            MODE_CAV_W: begin
                if (ctrl_ff[EXTPWM_BIT]) begin
                    nxt_drive = pwm_sync_ff[2] ? DRIVE_ACCEL : DRIVE_DECEL;
                end else if (ctrl_ff[KICK_BIT]) begin
                    nxt_drive = DRIVE_ACCEL;
                end else begin
                    nxt_drive = servo_cmd;
                end
            end
            MODE_CLV_W, MODE_CLV_N: nxt_drive = servo_cmd;
            default: nxt_drive = DRIVE_OFF;
        endcase
        if (ctrl_ff[LOW_POWER_SPINDLE_BIT] && mode != MODE_CLV_N && nxt_drive == DRIVE_DECEL) begin
            nxt_drive = DRIVE_OFF;
        end
        nxt_nco      = (mode == MODE_VCO_C) ? nco_ff + {6'h00, v16_word} : 16'h0000;
        nxt_phase    = (mode == MODE_CLV_W) && (velocity_ff < {1'b0, target});
        nxt_disc_clk = (mode == MODE_CAV_W);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drive_ff    <= DRIVE_OFF;
            nco_ff      <= 16'h0000;
            phase_ff    <= 1'b0;
            disc_clk_ff <= 1'b0;
        end else begin
            drive_ff    <= nxt_drive;
            nco_ff      <= nxt_nco;
            phase_ff    <= nxt_phase;
            disc_clk_ff <= nxt_disc_clk;
        end
    end

    assign s_axi_awready          = awready_ff;
    assign s_axi_wready           = wready_ff;
    assign s_axi_bvalid           = bvalid_ff;
    assign s_axi_bresp            = bresp_ff;
    assign s_axi_arready          = arready_ff;
    assign s_axi_rvalid           = rvalid_ff;
    assign s_axi_rdata            = rdata_ff;
    assign s_axi_rresp            = rresp_ff;
    assign spindle_drive_out      = drive_ff;
    assign serial_readout_pin     = readout_ff;
    assign vco_clock_sixteen      = nco_ff[15];
    assign phase_compare_out      = phase_ff;
    assign sample_clock_from_disc = disc_clk_ff;
endmodule
`default_nettype wire

// ===== src/spindle_pll_pkg.sv
// Constants shared by the spindle and clock-recovery mode controller.
package spindle_pll_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] PRESET_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS   = 8'h08;
    localparam logic [7:0] VELOCITY_OFS = 8'h0C;
    localparam logic [7:0] VCO_OFS      = 8'h10;
    localparam logic [7:0] OSC1_OFS     = 8'h14;
    localparam logic [7:0] CAPTURE_OFS  = 8'h18;
    // Control register field positions.
    localparam int MODE_LSB    = 0;
    localparam int EXTPWM_BIT  = 2;
    localparam int KICK_BIT    = 3;
    localparam int LOW_POWER_SPINDLE_BIT    = 4;
    localparam int PWMSEL_BIT  = 5;
    localparam int FLOFF_BIT   = 6;
    localparam int SPEED_BIT   = 7;
    localparam int RANGE_LSB   = 8;
    localparam int PITCH_BIT   = 10;
    // Reset values.
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    localparam logic [7:0]  PRESET_RST = 8'hE1;
    // Spindle and PLL operating modes.
    typedef enum logic [1:0] {MODE_CLV_N, MODE_CLV_W, MODE_CAV_W, MODE_VCO_C} spin_mode_t;
    // Spindle drive codes on the three-level output.
    localparam logic [1:0] DRIVE_OFF   = 2'h0;
    localparam logic [1:0] DRIVE_ACCEL = 2'h1;
    localparam logic [1:0] DRIVE_DECEL = 2'h2;
    // Velocity measurement: reference is the crystal divided by 128.
    localparam int          REF_DIV_BITS = 7;
    localparam logic [9:0]  MEAS_MAX     = 10'h03FF;
    localparam logic [8:0]  PRESET_BASE  = 9'h100;
    // Oscillator ratios for the first PLL oscillator.
    localparam logic [5:0]  OSC1_MUL     = 6'h31;
    localparam logic [4:0]  OSC1_DIV_LO  = 5'h18;
    localparam logic [4:0]  OSC1_DIV_HI  = 5'h10;
    // Clock recovery capture ranges in kHz.
    localparam logic [7:0]  CAPTURE_NARROW = 8'h96;
    localparam logic [7:0]  CAPTURE_FLOFF  = 8'h32;
    localparam logic [7:0]  CAPTURE_WIDE   = 8'hFF;
    // Auto lock sampling at 460 Hz from the 125 MHz clock.
    localparam int          CLK_HZ        = 125_000_000;
    localparam int          LOCK_SAMPLE_HZ = 460;
    localparam int          LOCK_SAMPLE_CYCLES = CLK_HZ / LOCK_SAMPLE_HZ;
    localparam logic [3:0]  LOCK_RUN      = 4'h8;
    // AXI response codes.
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
